// ### core/lsc_driver.v
// Purpose: Multiplexed segment display controller with register and memory port
// Assumes: CPU strobes and the subsystem tick are synchronous to I_MCLK
// Notes:   Pin outputs are drive level codes for an external analog stage
`timescale 1ns/1ps
`include "lsc_consts.vh"

// Notes on behaviour
// R1: Boost gain register holds only bit 0; other bits read zero; reset clears it.
// R2: Gain bit 0 selects 1.5x reference, gain bit 1 selects 1.0x reference.
// R3: Software changes boost gain only while the amplifier is disabled.
// R4: Bring-up order: clock divider, gain, slot count, then amplifier enable.
// R5: Software waits at least 500 ms after amplifier enable before enabling outputs.
// R6: Output control gives deselect level; display enable then drives memory contents.
// R7: Display memory sits at FA00 to FA0E, one byte per segment, readable and writable.
// R8: Memory bits unused by segments behave as ordinary RAM.
// R9: Upper four bits of every display byte are absent and read zero.
// R10: Commons are selected in turn over a repeating scan of three or four slots.
// R11: Bit k of each segment byte is used while common k is selected.
// R12: Stored one gives segment select level, stored zero gives deselect level.
// R13: In three-slot mode bit 3 never reaches an output; code drives it for a stale slot 3 until the next LCD clock.
// R14: Pixel is on only when common and segment are both selected.
// R15: Drive polarity alternates so no pair sees sustained DC.
// R16: Static mode drives the identical waveform on all four commons.
// R17: Display mode register: enable b7, amplifier b6, output control b4, slot select b0.
// R18: Output control zero grounds all pins; one gives deselect segments and scanning commons.
// R19: Clock control picks a source clock and a divider of 2^6 to 2^9.
// R20: Display byte n drives segment n.
// R21: Each slot lasts one LCD clock period; polarity inverts every frame.
// R22: With display enable zero no memory contents reach the segment pins.
module lsc_driver #(
    parameter NSEG = 15
) (
    input  wire              I_MCLK,
    input  wire              I_ARST_N,
    input  wire [15:0]       I_ADDR,
    input  wire              I_WR,
    input  wire              I_RD,
    input  wire [7:0]        I_WDATA,
    input  wire              I_SUB_TICK,
    input  wire              I_STATIC_MODE,
    output wire [7:0]        O_RDATA,
    output wire              O_HIT,
    output wire [7:0]        O_COM_LVL,
    output wire [2*NSEG-1:0] O_SEG_LVL,
    output wire              O_AMP_EN,
    output wire              O_REF_GAIN_1P5,
    output wire              O_LCD_TICK
);

    // Control registers
    reg               disp_en_q;
    reg               amp_en_q;
    reg               out_ctl_q;
    reg               slot_sel_q;
    reg  [3:0]        clkctl_q;
    reg               gain_q;
    reg  [7:0]        rdata_q;

    // Display memory, low nibble only
    reg  [3:0]        mem_q [0:NSEG-1];

    // Scan state
    reg  [1:0]        slot_q;
    reg  [1:0]        slot_d;
    reg               pol_q;
    reg               pol_d;

    // Pin level registers
    reg  [7:0]        com_lvl_q;
    reg  [7:0]        com_lvl_d;
    reg  [2*NSEG-1:0] seg_lvl_q;
    reg  [2*NSEG-1:0] seg_lvl_d;

    // Decode and clock wires
    wire              hit_mode;
    wire              hit_clk;
    wire              hit_gain;
    wire              hit_mem;
    wire [15:0]       mem_off;
    wire [3:0]        mem_idx;
    wire              pre_tick;
    wire              src_tick;
    wire              lcd_tick;
    wire [3:0]        pre_exp;
    wire [3:0]        div_exp;
    wire [1:0]        last_slot;

    reg  [7:0]        rd_mux;
    integer           n;
    integer           c;
    integer           m;

    // Reset images split into their implemented fields; a changed reset
    // value in the constants header then reaches every field register
    localparam [7:0]  rst_mode = `LSC_RST_MODE;
    localparam [7:0]  rst_clk  = `LSC_RST_CLKCTL;
    localparam [7:0]  rst_gain = `LSC_RST_GAIN;

    // Address decode
    assign hit_mode = (I_ADDR == `LSC_ADDR_MODE);
    assign hit_clk  = (I_ADDR == `LSC_ADDR_CLKCTL);
    assign hit_gain = (I_ADDR == `LSC_ADDR_GAIN);
    assign hit_mem  = (I_ADDR >= `LSC_ADDR_MEM_BASE) &&
                      (I_ADDR <= `LSC_ADDR_MEM_LAST);                  // see R7
    // Only the low nibble of the offset indexes; hit_mem keeps the index in range
    assign mem_off  = I_ADDR - `LSC_ADDR_MEM_BASE;
    assign mem_idx  = mem_off[3:0];
    assign O_HIT    = hit_mode | hit_clk | hit_gain | hit_mem;

    // Register writes; reserved bits are never stored, so they read zero
    always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            disp_en_q  <= rst_mode[`LSC_MODE_DISP_EN];                 // see R17
            amp_en_q   <= rst_mode[`LSC_MODE_AMP_EN];
            out_ctl_q  <= rst_mode[`LSC_MODE_OUT_CTL];
            slot_sel_q <= rst_mode[`LSC_MODE_SLOT_SEL];
            clkctl_q   <= rst_clk[3:0];
            gain_q     <= rst_gain[`LSC_GAIN_SEL];                     // see R1
        end else if (I_WR) begin
            if (hit_mode) begin
                disp_en_q  <= I_WDATA[`LSC_MODE_DISP_EN];              // see R6
                amp_en_q   <= I_WDATA[`LSC_MODE_AMP_EN];
                out_ctl_q  <= I_WDATA[`LSC_MODE_OUT_CTL];
                slot_sel_q <= I_WDATA[`LSC_MODE_SLOT_SEL];             // see R17
            end
            if (hit_clk) begin
                clkctl_q <= I_WDATA[3:0];                              // see R19
            end
            if (hit_gain) begin
                // Written regardless of amplifier state; keeping it off is software's job
                gain_q <= I_WDATA[`LSC_GAIN_SEL];                      // see R1
            end
        end
    end

    // Display memory writes; every cell is plain RAM, used by a segment or not
    always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            for (m = 0; m < NSEG; m = m + 1) begin
                mem_q[m] <= 4'h0;
            end
        end else if (I_WR && hit_mem) begin
            mem_q[mem_idx] <= I_WDATA[3:0];                            // see R8, R9
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always @* begin
        rd_mux = 8'h00;
        if (hit_mode) begin
            rd_mux[`LSC_MODE_DISP_EN]  = disp_en_q;
            rd_mux[`LSC_MODE_AMP_EN]   = amp_en_q;
            rd_mux[`LSC_MODE_OUT_CTL]  = out_ctl_q;
            rd_mux[`LSC_MODE_SLOT_SEL] = slot_sel_q;                   // see R17
        end else if (hit_clk) begin
            rd_mux[3:0] = clkctl_q;
        end else if (hit_gain) begin
            rd_mux[`LSC_GAIN_SEL] = gain_q;                            // see R1
        end else if (hit_mem) begin
            rd_mux[3:0] = mem_q[mem_idx];                              // see R9
        end
    end

    // Read data is captured on the read strobe and held until the next read
    // A read and a write to one cell in the same cycle return the old contents
    always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q <= 8'h00;
        end else if (I_RD) begin
            rdata_q <= rd_mux;                                         // see R7
        end
    end

    // Prescaler on the main clock gives fx/2^5, 2^6, 2^7 for sources 1 to 3
    // It runs from reset, so a source change never waits for a counter clear
    assign pre_exp = `LSC_PRE_EXP_BASE + {2'b00, clkctl_q[`LSC_CLK_SRC_HI:`LSC_CLK_SRC_LO]};

    lsc_pow2_div #(
        .CW       (8)
    ) u_pre_div (
        .i_clk    (I_MCLK),
        .i_arst_n (I_ARST_N),
        .i_tick   (1'b1),
        .i_exp    (pre_exp),
        .o_tick   (pre_tick)
    );

    // Source zero is the subsystem tick, the others come from the prescaler
    // Both sources are one-cycle pulses, so switching cannot stretch a tick
    assign src_tick = (clkctl_q[`LSC_CLK_SRC_HI:`LSC_CLK_SRC_LO] == 2'h0) ?
                      I_SUB_TICK : pre_tick;                           // see R19

    // LCD clock is the source divided by 2^6 to 2^9
    // Keeping the frame rate within the panel's limit is left to software
    assign div_exp = `LSC_DIV_EXP_BASE + {2'b00, clkctl_q[`LSC_CLK_DIV_HI:`LSC_CLK_DIV_LO]};

    lsc_pow2_div #(
        .CW       (10)
    ) u_lcd_div (
        .i_clk    (I_MCLK),
        .i_arst_n (I_ARST_N),
        .i_tick   (src_tick),
        .i_exp    (div_exp),
        .o_tick   (lcd_tick)
    );

    assign O_LCD_TICK = lcd_tick;

    // Last slot index of a frame; static mode has a single slot
    assign last_slot = I_STATIC_MODE ? 2'h0 :
                       (slot_sel_q ? `LSC_SLOTS_THREE : `LSC_SLOTS_FOUR); // see R10

    // Slot advances once per LCD clock; polarity flips at each frame end
    // The >= compare lets a stale slot 3 wrap at the next LCD clock after a switch to three slots
    always @* begin
        slot_d = slot_q;
        pol_d  = pol_q;
        if (lcd_tick) begin
            if (slot_q >= last_slot) begin
                slot_d = 2'h0;                                         // see R10
                pol_d  = ~pol_q;                                       // see R15, R21
            end else begin
                slot_d = slot_q + 2'h1;                                // see R21
            end
        end
    end

    // Scan state; the scan runs even with pins grounded, so the frame phase is free
    always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            slot_q <= 2'h0;
            pol_q  <= 1'b0;
        end else begin
            slot_q <= slot_d;
            pol_q  <= pol_d;
        end
    end

    // Common level: selected swings full scale, unselected sits at a bias level
    // Bias levels at a third and two thirds keep every deselected pair below threshold
    function [1:0] com_level;
        input sel;
        input pol;
        begin
            if (sel) begin
                com_level = pol ? `LSC_LV_GND : `LSC_LV_HIGH;
            end else begin
                com_level = pol ? `LSC_LV_MID : `LSC_LV_REF;
            end
        end
    endfunction

    // Segment level: select opposes the selected common, deselect stays within bias
    function [1:0] seg_level;
        input on;
        input pol;
        begin
            if (on) begin
                seg_level = pol ? `LSC_LV_HIGH : `LSC_LV_GND;
            end else begin
                seg_level = pol ? `LSC_LV_REF : `LSC_LV_MID;
            end
        end
    endfunction

    // Pin levels; output control low grounds everything
    always @* begin
        com_lvl_d = {4{`LSC_LV_GND}};
        seg_lvl_d = {NSEG{`LSC_LV_GND}};
        if (out_ctl_q) begin                                           // see R18
            for (c = 0; c < 4; c = c + 1) begin
                // In static mode every common is treated as selected
                com_lvl_d[2*c +: 2] = com_level(I_STATIC_MODE ||
                                                (slot_q == c[1:0]), pol_q); // see R10, R16
            end
            for (n = 0; n < NSEG; n = n + 1) begin
                // Slot 3 occurs in three-slot mode only as a stale slot until the next tick after a switch
                seg_lvl_d[2*n +: 2] = seg_level(disp_en_q &&
                                                mem_q[n][slot_q], pol_q); // see R11, R12, R13, R20, R22
            end
        end
    end

    // Registered pins; full difference only when both sides are selected
    // One register stage keeps decode glitches off the analog level switches
    always @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            com_lvl_q <= {4{`LSC_LV_GND}};
            seg_lvl_q <= {NSEG{`LSC_LV_GND}};
        end else begin
            com_lvl_q <= com_lvl_d;                                    // see R14
            seg_lvl_q <= seg_lvl_d;                                    // see R14, R6
        end
    end

    assign O_COM_LVL      = com_lvl_q;
    assign O_SEG_LVL      = seg_lvl_q;
    assign O_RDATA        = rdata_q;
    assign O_AMP_EN       = amp_en_q;
    assign O_REF_GAIN_1P5 = ~gain_q;                                   // see R2

endmodule // lsc_driver

// ### core/lsc_consts.vh
// Purpose: Shared constants for the segment display driver
// Assumes: Byte-wide CPU data port, 16-bit addresses
// Notes:   Drive levels are 2-bit codes; the analog stage turns them into voltages
`ifndef LSC_CONSTS_VH
`define LSC_CONSTS_VH

// Register and memory addresses
`define LSC_ADDR_MODE        16'hFFB0
`define LSC_ADDR_CLKCTL      16'hFFB2
`define LSC_ADDR_GAIN        16'hFFB3
`define LSC_ADDR_MEM_BASE    16'hFA00
`define LSC_ADDR_MEM_LAST    16'hFA0E

// Reset values
`define LSC_RST_MODE         8'h00
`define LSC_RST_CLKCTL       8'h00
`define LSC_RST_GAIN         8'h00

// Display mode register fields
`define LSC_MODE_DISP_EN     7
`define LSC_MODE_AMP_EN      6
`define LSC_MODE_OUT_CTL     4
`define LSC_MODE_SLOT_SEL    0

// Clock control fields: bits 3:2 source, bits 1:0 divider
`define LSC_CLK_SRC_HI       3
`define LSC_CLK_SRC_LO       2
`define LSC_CLK_DIV_HI       1
`define LSC_CLK_DIV_LO       0

// Boost gain field
`define LSC_GAIN_SEL         0

// Divider exponents
`define LSC_PRE_EXP_BASE     4'h4
`define LSC_DIV_EXP_BASE     4'h6

// Scan lengths, as last slot index
`define LSC_SLOTS_FOUR       2'h3
`define LSC_SLOTS_THREE      2'h2

// Drive level codes
`define LSC_LV_GND           2'h0
`define LSC_LV_REF           2'h1
`define LSC_LV_MID           2'h2
`define LSC_LV_HIGH          2'h3

`endif

// ### core/lsc_pow2_div.v
// Purpose: Power-of-two tick divider with selectable exponent
// Assumes: i_tick is a count enable in the clock domain, a one-cycle pulse or tied high
// Notes:   Output pulse is registered, one cycle after the qualifying input tick
`timescale 1ns/1ps

module lsc_pow2_div #(
    parameter CW = 10
) (
    input  wire        i_clk,
    input  wire        i_arst_n,
    input  wire        i_tick,
    input  wire [3:0]  i_exp,
    output wire        o_tick
);

    reg  [CW-1:0] cnt_q;
    reg           tick_q;
    reg  [CW-1:0] mask;
    integer       k;

    // Mask of the low exponent bits; the masked count wraps every 2^exp ticks
    always @* begin
        mask = {CW{1'b0}};
        for (k = 0; k < CW; k = k + 1) begin
            if (k < i_exp) begin
                mask[k] = 1'b1;
            end
        end
    end

    // Free-running counter; an exponent change only shifts the next edge
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q  <= {CW{1'b0}};
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (i_tick) begin
                cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
                if ((cnt_q & mask) == mask) begin
                    tick_q <= 1'b1;
                end
            end
        end
    end

    assign o_tick = tick_q;

endmodule // lsc_pow2_div

// ### sim/lsc_glass.sv
// Purpose: Behavioural segment glass seen from the drive pins
// Assumes: Level codes 0 ground, 1 ref, 2 mid, 3 high
// Notes:   Only full-swing pairs light a pixel; partial swings stay dark
`timescale 1ns/1ps
module lsc_glass #(
    parameter NSEG = 15
) (
    input  wire  [7:0]        i_com_lvl,
    input  wire  [2*NSEG-1:0] i_seg_lvl,
    output logic [4*NSEG-1:0] o_px_on
);
    // Pixel k,n lights on a full swing either way, so both polarities count
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            for (int n = 0; n < NSEG; n++) begin
                o_px_on[k*NSEG+n] = {i_com_lvl[2*k+:2], i_seg_lvl[2*n+:2]} == 4'hC
                                 || {i_com_lvl[2*k+:2], i_seg_lvl[2*n+:2]} == 4'h3;
            end
        end
    end
endmodule // lsc_glass

// ### sim/lsc_driver_asserts.sv
// Purpose: Port-level checks of the segment display driver
// Assumes: All strobes and pins belong to I_MCLK
// Notes:   Mode bits are shadowed from bus writes, as no port shows them except the amplifier enable
`timescale 1ns/1ps
`include "lsc_consts.vh"
module lsc_driver_asserts #(
    parameter NSEG = 15
) (
    input wire              I_MCLK,
    input wire              I_ARST_N,
    input wire [15:0]       I_ADDR,
    input wire              I_WR,
    input wire              I_RD,
    input wire [7:0]        I_WDATA,
    input wire              I_SUB_TICK,
    input wire              I_STATIC_MODE,
    input wire [7:0]        O_RDATA,
    input wire              O_HIT,
    input wire [7:0]        O_COM_LVL,
    input wire [2*NSEG-1:0] O_SEG_LVL,
    input wire              O_AMP_EN,
    input wire              O_REF_GAIN_1P5,
    input wire              O_LCD_TICK
);
    logic [7:0] mode_q;
    logic       desel_all;
    logic       in_mem;
    // Shadow of the mode register, keeping only the implemented bits
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) mode_q <= 8'h00;
        else if (I_WR && I_ADDR == `LSC_ADDR_MODE) mode_q <= I_WDATA & 8'hD1;
    end
    // Deselect codes are 1 and 2; 0 and 3 would light a selected pixel
    always_comb begin
        desel_all = 1'b1;
        for (int n = 0; n < NSEG; n++)
            if (O_SEG_LVL[2*n+:2] == 2'h0 || O_SEG_LVL[2*n+:2] == 2'h3) desel_all = 1'b0;
    end
    assign in_mem = I_ADDR >= `LSC_ADDR_MEM_BASE && I_ADDR <= `LSC_ADDR_MEM_LAST;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_ARST_N);
    a_gain_map: assert property (I_WR && I_ADDR == `LSC_ADDR_GAIN
        |=> O_REF_GAIN_1P5 == !$past(I_WDATA[0])) else $error("gain output wrong");
    a_amp_follow: assert property (I_WR && I_ADDR == `LSC_ADDR_MODE
        |=> O_AMP_EN == $past(I_WDATA[6])) else $error("amplifier enable wrong");
    a_hit_decode: assert property (O_HIT == (in_mem || I_ADDR == `LSC_ADDR_MODE
        || I_ADDR == `LSC_ADDR_CLKCTL || I_ADDR == `LSC_ADDR_GAIN)) else $error("bad decode");
    a_gain_rd_zero: assert property (I_RD && I_ADDR == `LSC_ADDR_GAIN
        |=> O_RDATA[7:1] == 7'h00) else $error("gain upper bits not zero");
    a_mem_nibble: assert property (I_RD && in_mem |=> O_RDATA[7:4] == 4'h0)
        else $error("memory upper nibble not zero");
    a_unmapped_rd: assert property (I_RD && !O_HIT |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_tick_pulse: assert property (O_LCD_TICK |=> !O_LCD_TICK)
        else $error("tick longer than a cycle");
    a_pins_ground: assert property ((!mode_q[4])[*2]
        |-> O_COM_LVL == 8'h00 && O_SEG_LVL == '0) else $error("pins not grounded");
    a_seg_desel: assert property ((mode_q[4] && !mode_q[7])[*2] |-> desel_all)
        else $error("segment not deselected");
    a_static_same: assert property ((I_STATIC_MODE && mode_q[4])[*2]
        |-> O_COM_LVL == {4{O_COM_LVL[1:0]}} && (O_COM_LVL[1:0] == 2'h3
        || O_COM_LVL[1:0] == 2'h0)) else $error("static commons differ");
endmodule // lsc_driver_asserts
bind lsc_driver lsc_driver_asserts #(.NSEG(NSEG)) u_chk (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N),
    .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .I_SUB_TICK(I_SUB_TICK),
    .I_STATIC_MODE(I_STATIC_MODE), .O_RDATA(O_RDATA), .O_HIT(O_HIT), .O_COM_LVL(O_COM_LVL),
    .O_SEG_LVL(O_SEG_LVL), .O_AMP_EN(O_AMP_EN), .O_REF_GAIN_1P5(O_REF_GAIN_1P5),
    .O_LCD_TICK(O_LCD_TICK));

// ### sim/tb_lsc_driver.sv
// Purpose: Self-checking bench for the segment display driver
// Assumes: Clock control 04 gives one slot every 2048 cycles
// Notes:   The amplifier settling wait is cut short; no analog stage is modelled
`timescale 1ns/1ps
`include "lsc_consts.vh"
module tb_lsc_driver;
    localparam int NSEG = 15;
    logic              I_MCLK = 1'b0, I_ARST_N = 1'b0, I_WR = 1'b0, I_RD = 1'b0;
    logic              I_SUB_TICK = 1'b0, I_STATIC_MODE = 1'b0;
    logic [15:0]       I_ADDR = 16'h0000;
    logic [7:0]        I_WDATA = 8'h00, d;
    wire  [7:0]        O_RDATA, O_COM_LVL;
    wire  [2*NSEG-1:0] O_SEG_LVL;
    wire               O_HIT, O_AMP_EN, O_REF_GAIN_1P5, O_LCD_TICK;
    wire  [4*NSEG-1:0] px_on;
    logic [7:0]        exp_q[$];
    logic [3:0]        mem[NSEG];
    int                errors = 0, cmp_count = 0;
    lsc_driver #(.NSEG(NSEG)) u_dut (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR),
        .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .I_SUB_TICK(I_SUB_TICK),
        .I_STATIC_MODE(I_STATIC_MODE), .O_RDATA(O_RDATA), .O_HIT(O_HIT), .O_COM_LVL(O_COM_LVL),
        .O_SEG_LVL(O_SEG_LVL), .O_AMP_EN(O_AMP_EN), .O_REF_GAIN_1P5(O_REF_GAIN_1P5),
        .O_LCD_TICK(O_LCD_TICK));
    lsc_glass #(.NSEG(NSEG)) u_glass (.i_com_lvl(O_COM_LVL), .i_seg_lvl(O_SEG_LVL),
        .o_px_on(px_on));
    // Clock and a slow subsystem tick so the source-0 path sees activity
    always #10 I_MCLK = ~I_MCLK;
    always begin
        repeat (7) @(posedge I_MCLK);
        #1 I_SUB_TICK = 1'b1;
        @(posedge I_MCLK);
        #1 I_SUB_TICK = 1'b0;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bus strobes are single-cycle; the strobe drops one cycle after launch
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge I_MCLK);
        #1 {I_ADDR, I_WDATA, I_WR} = {a, v, 1'b1};
        @(posedge I_MCLK);
        #1 I_WR = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge I_MCLK);
        #1 {I_ADDR, I_RD} = {a, 1'b1};
        exp_q.push_back(e);
        @(posedge I_MCLK);
        #1 I_RD = 1'b0;
    endtask
    // Scoreboard: each answered read takes the oldest note
    always @(posedge I_MCLK) begin
        if (I_RD === 1'b1) begin
            #2;
            chk(O_RDATA, exp_q.pop_front());
        end
    end
    // Bounded wait for a slot tick, then let the pin register settle
    task automatic slot_wait();
        int i;
        for (i = 0; i < 3000 && O_LCD_TICK !== 1'b1; i++) begin
            @(posedge I_MCLK);
            #1;
        end
        chk(i < 3000, 1);
        repeat (3) @(posedge I_MCLK);
        #2;
    endtask
    // Two ticks are skipped so a stale divider phase cannot distort the period
    task automatic tick_period(input int exp_n);
        int i, t;
        repeat (2) begin
            for (i = 0; i < 5000 && O_LCD_TICK !== 1'b1; i++) begin
                @(posedge I_MCLK);
                #1;
            end
            @(posedge I_MCLK);
            #1;
        end
        for (t = 1; t < 5000 && O_LCD_TICK !== 1'b1; t++) begin
            @(posedge I_MCLK);
            #1;
        end
        chk(t, exp_n);
    endtask
    task automatic scan(input int nsl, input int nt);
        int prv, sl, pol, ppol, nsel;
        prv = -1;
        repeat (nt) begin
            slot_wait();
            nsel = 0;
            for (int k = 0; k < 4; k++) begin
                if (O_COM_LVL[2*k+:2] == 2'h3 || O_COM_LVL[2*k+:2] == 2'h0) begin
                    nsel++;
                    sl = k;
                    pol = (O_COM_LVL[2*k+:2] == 2'h0);
                end
            end
            chk(nsel, 1);
            for (int k = 0; k < 4; k++)
                for (int n = 0; n < NSEG; n++)
                    chk(px_on[k*NSEG+n], k == sl && mem[n][sl]);
            if (prv >= 0) chk(sl, (prv + 1) % nsl);
            if (prv >= 0) chk(pol, (sl == 0) ? !ppol : ppol);
            prv = sl;
            ppol = pol;
        end
        $display("test scan of %0d slots done", nsl);
    endtask
    // Watchdog: about 20 slots of 2048 cycles, clock measurements and bus traffic
    initial begin
        #1800000;
        errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'hA0631C57));
        repeat (5) @(posedge I_MCLK);
        #1 I_ARST_N = 1'b1;
        rd(`LSC_ADDR_MODE, 8'h00);
        rd(`LSC_ADDR_CLKCTL, 8'h00);
        rd(`LSC_ADDR_GAIN, 8'h00);
        chk(O_REF_GAIN_1P5, 1);
        $display("test reset values done");
        repeat (4) begin
            d = $urandom;
            wr(`LSC_ADDR_GAIN, d);
            chk(O_REF_GAIN_1P5, !d[0]);
            rd(`LSC_ADDR_GAIN, {7'h00, d[0]});
        end
        $display("test gain done");
        // Full random bytes: the absent upper nibble must not be stored
        for (int n = 0; n < NSEG; n++) begin
            d = $urandom;
            mem[n] = d[3:0];
            wr(`LSC_ADDR_MEM_BASE + n, d);
        end
        for (int n = 0; n < NSEG; n++) rd(`LSC_ADDR_MEM_BASE + n, {4'h0, mem[n]});
        wr(16'hFA0F, 8'hFF);
        rd(16'hFA0F, 8'h00);
        rd(16'hFFB1, 8'h00);
        $display("test memory done");
        // Sub tick every 8 cycles times 2^6; then prescale 2^5 times 2^7
        wr(`LSC_ADDR_CLKCTL, 8'h00);
        tick_period(8 * 64);
        wr(`LSC_ADDR_CLKCTL, 8'hF5);
        rd(`LSC_ADDR_CLKCTL, 8'h05);
        tick_period(32 * 128);
        $display("test clock select done");
        wr(`LSC_ADDR_CLKCTL, 8'h04);
        wr(`LSC_ADDR_GAIN, 8'h00);
        wr(`LSC_ADDR_MODE, 8'h00);
        wr(`LSC_ADDR_MODE, 8'h40);
        chk(O_AMP_EN, 1);
        wr(`LSC_ADDR_MODE, 8'h50);
        slot_wait();
        chk(px_on, 0);
        wr(`LSC_ADDR_MODE, 8'hD0);
        scan(4, 8);
        wr(`LSC_ADDR_MODE, 8'hD1);
        scan(3, 7);
        @(posedge I_MCLK);
        #1 I_STATIC_MODE = 1'b1;
        slot_wait();
        d = O_COM_LVL;
        chk(d == 8'hFF || d == 8'h00, 1);
        slot_wait();
        chk(O_COM_LVL, {4{~d[1:0]}});
        for (int k = 0; k < 4; k++)
            for (int n = 0; n < NSEG; n++)
                chk(px_on[k*NSEG+n], mem[n][0]);
        @(posedge I_MCLK);
        #1 I_STATIC_MODE = 1'b0;
        wr(`LSC_ADDR_MODE, 8'h00);
        repeat (3) @(posedge I_MCLK);
        chk({O_COM_LVL, O_SEG_LVL}, 0);
        $display("test static and shutdown done");
        conclude();
    end
endmodule // tb_lsc_driver
